// [core/cfa_file_cmd.sv]
/*
  Card side interpreter for status, transparent read, transparent update
  and record read, with per-file record pointers.
  Assumes the surrounding logic resolves tgt_file_o into the file attribute
  inputs in the same cycle, and that all inputs come from clk_i logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfa_map.svh"

module cfa_file_cmd #(
  parameter int SLOT_AW = 8
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // command
  input  wire logic                  cmd_valid_i,
  output logic                       cmd_ready_o,
  input  wire cfa_pkg::cfa_ins_e     cmd_ins_i,
  input  wire logic [7:0]            cmd_p1_i,
  input  wire logic [7:0]            cmd_p2_i,
  input  wire logic [7:0]            cmd_len_i,
  // update data
  input  wire logic                  wr_valid_i,
  input  wire logic [7:0]            wr_data_i,
  output logic                       wr_ready_o,
  // response data
  output logic                       rsp_valid_o,
  output logic [7:0]                 rsp_data_o,
  output logic                       rsp_last_o,
  input  wire logic                  rsp_ready_i,
  // completion
  output logic                       done_o,
  output cfa_pkg::cfa_status_e       status_o,
  // file context
  input  wire logic [4:0]            sel_file_i,
  input  wire logic                  sel_pulse_i,
  output logic [4:0]                 tgt_file_o,
  input  wire cfa_pkg::cfa_kind_e    tgt_kind_i,
  input  wire logic [SLOT_AW:0]      tgt_size_i,
  input  wire logic [7:0]            tgt_rec_len_i,
  input  wire logic [7:0]            tgt_rec_cnt_i,
  input  wire logic                  tgt_read_ok_i,
  input  wire logic                  tgt_update_ok_i,
  input  wire logic [7:0]            fcp_len_i,
  input  wire logic [7:0]            name_len_i,
  // application indication
  output cfa_pkg::cfa_app_e          app_ind_o,
  output logic                       app_ind_stb_o
);
  import cfa_pkg::*;

  localparam int AW = SLOT_AW + 5;

  typedef enum logic [1:0] {
    CFA_FSM_IDLE  = 2'b00,
    CFA_FSM_ISSUE = 2'b01,
    CFA_FSM_HOLD  = 2'b10,
    CFA_FSM_WRITE = 2'b11
  } cfa_fsm_e;

  cfa_mem_if #(.AW(AW)) mem_bus ();

  cfa_byte_mem #(.AW(AW)) u_mem (
    .clk_i (clk_i),
    .m     (mem_bus.mem)
  );

  // shared offset and file decode of both transparent commands
  function automatic cfa_bin_s bin_decode(input logic [7:0] p1, input logic [7:0] p2,
                                          input logic [4:0] cur);
    cfa_bin_s r;
    r = '0;
    if (!p1[`CFA_BIN_OFS_BIT]) begin
      r.ok   = 1'b1;
      r.file = cur;
      r.off  = {p1[6:0], p2};
    end else if (p1[7:5] == `CFA_BIN_SFI_TAG && p1[4:0] != `CFA_REC_CUR_FILE
                 && p1[4:0] != `CFA_SFI_RFU) begin
      r.ok   = 1'b1;
      r.file = p1[4:0];
      r.off  = {7'h00, p2};
    end
    return r;
  endfunction : bin_decode

  // record selection and pointer movement for one record read
  function automatic cfa_rec_s rec_step(input logic [2:0] mode, input logic [7:0] p1,
                                        input logic [7:0] ptr, input logic [7:0] cnt,
                                        input logic cyc);
    cfa_rec_s r;
    r.ok  = 1'b1;
    r.rec = ptr;
    r.ptr = ptr;
    unique case (mode)
      `CFA_MODE_NEXT: begin
        if (ptr == `CFA_PTR_UNSET) begin
          r.rec = `CFA_REC_FIRST;
        end else if (ptr >= cnt) begin
          r.ok  = cyc;
          r.rec = `CFA_REC_FIRST;
        end else begin
          r.rec = ptr + 8'h01;
        end
        r.ptr = r.ok ? r.rec : ptr;
      end
      `CFA_MODE_PREV: begin
        if (ptr == `CFA_PTR_UNSET) begin
          r.rec = cnt;
        end else if (ptr == `CFA_REC_FIRST) begin
          r.ok  = cyc;
          r.rec = cnt;
        end else begin
          r.rec = ptr - 8'h01;
        end
        r.ptr = r.ok ? r.rec : ptr;
      end
      default: begin
        // absolute or current: pointer left alone
        r.rec = (p1 == `CFA_REC_CURRENT) ? ptr : p1;
        r.ok  = (r.rec != `CFA_PTR_UNSET) && (r.rec <= cnt);
      end
    endcase
    return r;
  endfunction : rec_step

  cfa_fsm_e         st_q, st_d;
  logic [4:0]       file_q, file_d;
  logic [SLOT_AW-1:0] addr_q, addr_d;
  logic [8:0]       cnt_q, cnt_d;
  cfa_status_e      status_q, status_d;
  logic             done_q, done_d;
  cfa_app_e         app_q, app_d;
  logic             stb_q, stb_d;
  logic [7:0]       ptr_q [32];
  logic [7:0]       ptr_d [32];

  cfa_bin_s         bin;
  cfa_rec_s         rec;
  logic [4:0]       rec_file;
  logic             p2_rfu;
  logic             take;
  logic [8:0]       nbytes;
  logic [7:0]       src_len;
  logic [15:0]      rec_ofs;

  assign take     = (st_q == CFA_FSM_IDLE) && cmd_valid_i;
  assign bin      = bin_decode(cmd_p1_i, cmd_p2_i, sel_file_i);
  assign rec_file = (cmd_p2_i[7:3] == `CFA_REC_CUR_FILE) ? sel_file_i : cmd_p2_i[7:3];
  assign p2_rfu   = (cmd_p2_i[7:3] == `CFA_SFI_RFU) ||
                    ((cmd_p2_i[2:0] != `CFA_MODE_NEXT) && (cmd_p2_i[2:0] != `CFA_MODE_PREV)
                     && (cmd_p2_i[2:0] != `CFA_MODE_ABS));
  assign rec      = rec_step(cmd_p2_i[2:0], cmd_p1_i, ptr_q[rec_file], tgt_rec_cnt_i,
                             tgt_kind_i == CFA_KIND_CYCLIC);
  assign rec_ofs  = (16'(rec.rec) - 16'h0001) * 16'(tgt_rec_len_i);
  assign src_len  = (cmd_p2_i == `CFA_P2_SELECT_RSP) ? fcp_len_i : name_len_i;

  always_comb begin
    unique case (cmd_ins_i)
      CFA_INS_READ_REC: tgt_file_o = rec_file;
      default:          tgt_file_o = bin.file;
    endcase
  end

  always_comb begin
    st_d     = st_q;
    file_d   = file_q;
    addr_d   = addr_q;
    cnt_d    = cnt_q;
    status_d = status_q;
    done_d   = 1'b0;
    app_d    = app_q;
    stb_d    = 1'b0;
    ptr_d    = ptr_q;
    nbytes   = 9'h000;
    if (sel_pulse_i) begin
      for (int i = 0; i < 32; i++) begin
        ptr_d[i] = `CFA_PTR_UNSET;
      end
    end
    unique case (st_q)
      CFA_FSM_IDLE: begin
        if (take) begin
          done_d   = 1'b1;
          status_d = CFA_ST_OK;
          unique case (cmd_ins_i)
            CFA_INS_STATUS: begin
              if (cmd_p1_i > `CFA_P1_APP_TERM ||
                  (cmd_p2_i != `CFA_P2_SELECT_RSP && cmd_p2_i != `CFA_P2_NAME_RSP
                   && cmd_p2_i != `CFA_P2_NO_DATA)) begin
                status_d = CFA_ST_BAD_PARAM;
              end else begin
                stb_d = (cmd_p1_i != `CFA_P1_NO_IND);
                app_d = (cmd_p1_i == `CFA_P1_APP_INIT) ? CFA_APP_INIT :
                        (cmd_p1_i == `CFA_P1_APP_TERM) ? CFA_APP_TERM : CFA_APP_NONE;
                if (cmd_p2_i != `CFA_P2_NO_DATA && src_len != 8'h00) begin
                  // zero or absent length means everything available
                  nbytes = (cmd_len_i == 8'h00 || cmd_len_i > src_len) ?
                           {1'b0, src_len} : {1'b0, cmd_len_i};
                  file_d = (cmd_p2_i == `CFA_P2_SELECT_RSP) ? `CFA_FCP_SLOT :
                           `CFA_NAME_SLOT;
                  addr_d = '0;
                  cnt_d  = nbytes;
                  done_d = 1'b0;
                  st_d   = CFA_FSM_ISSUE;
                end
              end
            end
            CFA_INS_READ_BIN, CFA_INS_UPD_BIN: begin
              if (cmd_ins_i == CFA_INS_READ_BIN) begin
                nbytes = (cmd_len_i == 8'h00) ? `CFA_LE_FULL : {1'b0, cmd_len_i};
              end else begin
                nbytes = {1'b0, cmd_len_i};
              end
              if (!bin.ok) begin
                status_d = CFA_ST_BAD_PARAM;
              end else if (tgt_kind_i != CFA_KIND_TRANSPARENT) begin
                status_d = CFA_ST_KIND;
              end else if (cmd_ins_i == CFA_INS_READ_BIN ? !tgt_read_ok_i
                                                          : !tgt_update_ok_i) begin
                status_d = CFA_ST_ACCESS;
              end else if (16'(bin.off) + 16'(nbytes) > 16'(tgt_size_i)) begin
                status_d = CFA_ST_RANGE;
              end else if (nbytes != 9'h000) begin
                file_d = bin.file;
                addr_d = bin.off[SLOT_AW-1:0];
                cnt_d  = nbytes;
                done_d = 1'b0;
                st_d   = (cmd_ins_i == CFA_INS_READ_BIN) ? CFA_FSM_ISSUE : CFA_FSM_WRITE;
              end
            end
            CFA_INS_READ_REC: begin
              if (p2_rfu) begin
                status_d = CFA_ST_BAD_PARAM;
              end else if (tgt_kind_i == CFA_KIND_TRANSPARENT || tgt_rec_len_i == 8'h00
                           || tgt_rec_cnt_i == 8'h00) begin
                status_d = CFA_ST_KIND;
              end else if (!tgt_read_ok_i) begin
                status_d = CFA_ST_ACCESS;
              end else if (!rec.ok) begin
                status_d = CFA_ST_NO_RECORD;
              end else if (rec_ofs + 16'(tgt_rec_len_i) > 16'(tgt_size_i)) begin
                status_d = CFA_ST_RANGE;
              end else begin
                ptr_d[rec_file] = rec.ptr;
                file_d = rec_file;
                addr_d = rec_ofs[SLOT_AW-1:0];
                cnt_d  = {1'b0, tgt_rec_len_i};
                done_d = 1'b0;
                st_d   = CFA_FSM_ISSUE;
              end
            end
          endcase
        end
      end
      CFA_FSM_ISSUE: begin
        st_d = CFA_FSM_HOLD;
      end
      CFA_FSM_HOLD: begin
        if (rsp_ready_i) begin
          addr_d = addr_q + 1'b1;
          cnt_d  = cnt_q - 9'h001;
          if (cnt_q == 9'h001) begin
            done_d = 1'b1;
            st_d   = CFA_FSM_IDLE;
          end else begin
            st_d = CFA_FSM_ISSUE;
          end
        end
      end
      CFA_FSM_WRITE: begin
        if (wr_valid_i) begin
          addr_d = addr_q + 1'b1;
          cnt_d  = cnt_q - 9'h001;
          if (cnt_q == 9'h001) begin
            done_d = 1'b1;
            st_d   = CFA_FSM_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q     <= CFA_FSM_IDLE;
      file_q   <= 5'h00;
      addr_q   <= '0;
      cnt_q    <= 9'h000;
      status_q <= CFA_ST_OK;
      done_q   <= 1'b0;
      app_q    <= CFA_APP_NONE;
      stb_q    <= 1'b0;
      for (int i = 0; i < 32; i++) begin
        ptr_q[i] <= `CFA_PTR_UNSET;
      end
    end else begin
      st_q     <= st_d;
      file_q   <= file_d;
      addr_q   <= addr_d;
      cnt_q    <= cnt_d;
      status_q <= status_d;
      done_q   <= done_d;
      app_q    <= app_d;
      stb_q    <= stb_d;
      ptr_q    <= ptr_d;
    end
  end

  // memory side: one read per byte, rdata held while the terminal stalls
  assign mem_bus.re    = (st_q == CFA_FSM_ISSUE);
  assign mem_bus.raddr = {file_q, addr_q};
  assign mem_bus.we    = (st_q == CFA_FSM_WRITE) && wr_valid_i;
  assign mem_bus.waddr = {file_q, addr_q};
  assign mem_bus.wdata = wr_data_i;

  assign cmd_ready_o   = (st_q == CFA_FSM_IDLE);
  assign wr_ready_o    = (st_q == CFA_FSM_WRITE);
  assign rsp_valid_o   = (st_q == CFA_FSM_HOLD);
  assign rsp_data_o    = mem_bus.rdata;
  assign rsp_last_o    = (st_q == CFA_FSM_HOLD) && (cnt_q == 9'h001);
  assign done_o        = done_q;
  assign status_o      = status_q;
  assign app_ind_o     = app_q;
  assign app_ind_stb_o = stb_q;

endmodule : cfa_file_cmd

`default_nettype wire

// [core/cfa_map.svh]
/*
  Constants of the card file access command interpreter: parameter codings,
  reserved storage slots and reset values.
  Assumes it is included by its bare name from the modules.
*/
// What this block does
// - status first parameter carries application indication
// - status second parameter selects response kind
// - reads need read access condition satisfied
// - transparent update needs update access condition
// - bit8 clear: seven-bit high offset plus low
// - top bits 100: short file ref, byte offset
// - transparent read returns exactly expected-length bytes
// - transparent update overwrites bytes from offset
// - update decodes offset exactly like read
// - failed record read leaves pointer unchanged
// - current and absolute modes never move pointer
// - next advances pointer; unset gives first record
// - linear file at last: next does nothing
// - cyclic file at last: next wraps first
// - previous steps back; unset gives last record
// - linear file at first: previous does nothing
// - cyclic file at first: previous wraps last
// - mode byte top five bits select file
// - low three bits select next/previous/absolute
`ifndef CFA_MAP_SVH
`define CFA_MAP_SVH

`define CFA_P1_NO_IND     8'h00
`define CFA_P1_APP_INIT   8'h01
`define CFA_P1_APP_TERM   8'h02
`define CFA_P2_SELECT_RSP 8'h00
`define CFA_P2_NAME_RSP   8'h01
`define CFA_P2_NO_DATA    8'h0C
`define CFA_BIN_OFS_BIT   7
`define CFA_BIN_SFI_TAG   3'h4
`define CFA_REC_CUR_FILE  5'h00
`define CFA_SFI_RFU       5'h1F
`define CFA_MODE_NEXT     3'h2
`define CFA_MODE_PREV     3'h3
`define CFA_MODE_ABS      3'h4
`define CFA_REC_CURRENT   8'h00
`define CFA_PTR_UNSET     8'h00
`define CFA_REC_FIRST     8'h01
`define CFA_FCP_SLOT      5'h1F
`define CFA_NAME_SLOT     5'h00
`define CFA_LE_FULL       9'h100

`endif

// [core/cfa_pkg.sv]
/*
  Types of the card file access command interpreter.
  Assumes cfa_map.svh is on the include path.
*/
package cfa_pkg;

  typedef enum logic [1:0] {
    CFA_INS_STATUS   = 2'b00,
    CFA_INS_READ_BIN = 2'b01,
    CFA_INS_UPD_BIN  = 2'b10,
    CFA_INS_READ_REC = 2'b11
  } cfa_ins_e;

  typedef enum logic [2:0] {
    CFA_ST_OK        = 3'b000,
    CFA_ST_BAD_PARAM = 3'b001,
    CFA_ST_ACCESS    = 3'b010,
    CFA_ST_RANGE     = 3'b011,
    CFA_ST_NO_RECORD = 3'b100,
    CFA_ST_KIND      = 3'b101
  } cfa_status_e;

  typedef enum logic [1:0] {
    CFA_KIND_TRANSPARENT = 2'b00,
    CFA_KIND_LINEAR      = 2'b01,
    CFA_KIND_CYCLIC      = 2'b10
  } cfa_kind_e;

  typedef enum logic [1:0] {
    CFA_APP_NONE = 2'b00,
    CFA_APP_INIT = 2'b01,
    CFA_APP_TERM = 2'b10
  } cfa_app_e;

  typedef struct packed {
    logic        ok;
    logic [4:0]  file;
    logic [14:0] off;
  } cfa_bin_s;

  typedef struct packed {
    logic       ok;
    logic [7:0] rec;
    logic [7:0] ptr;
  } cfa_rec_s;

endpackage : cfa_pkg

// [core/cfa_mem_if.sv]
/*
  Port bundle between the interpreter and its byte store.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none

interface cfa_mem_if #(parameter int AW = 13);
  logic          we;
  logic [AW-1:0] waddr;
  logic [7:0]    wdata;
  logic          re;
  logic [AW-1:0] raddr;
  logic [7:0]    rdata;

  modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
  modport mem  (input we, waddr, wdata, re, raddr, output rdata);
endinterface : cfa_mem_if

`default_nettype wire

// [core/cfa_byte_mem.sv]
/*
  Byte store holding all file slots; registered read data.
  Assumes the controller holds re low while it wants rdata to stay put.
*/
`timescale 1ns/1ps
`default_nettype none

module cfa_byte_mem #(
  parameter int AW = 13
) (
  input  wire logic clk_i,
  cfa_mem_if.mem    m
);

  logic [7:0] store [2**AW];
  logic [7:0] rdata_q;

  // contents are not reset: file data survives a command-level reset
  always_ff @(posedge clk_i) begin
    if (m.we) begin
      store[m.waddr] <= m.wdata;
    end
    if (m.re) begin
      rdata_q <= store[m.raddr];
    end
  end

  assign m.rdata = rdata_q;

endmodule : cfa_byte_mem

`default_nettype wire

// [verification/cfa_file_cmd_chk.sv]
/*
  Concurrent checks on the ports of the card file access interpreter.
  Assumes one clock, synchronous active-high reset, bound to cfa_file_cmd.
*/
`timescale 1ns/1ps
`default_nettype none

module cfa_file_cmd_chk #(
  parameter int SLOT_AW = 8
) (
  // watched ports
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 cmd_valid_i,
  input wire logic                 cmd_ready_o,
  input wire cfa_pkg::cfa_ins_e    cmd_ins_i,
  input wire logic [7:0]           cmd_p1_i,
  input wire logic [7:0]           cmd_p2_i,
  input wire logic                 wr_ready_o,
  input wire logic                 rsp_valid_o,
  input wire logic [7:0]           rsp_data_o,
  input wire logic                 rsp_last_o,
  input wire logic                 rsp_ready_i,
  input wire logic                 done_o,
  input wire cfa_pkg::cfa_status_e status_o,
  input wire cfa_pkg::cfa_kind_e   tgt_kind_i,
  input wire logic                 tgt_read_ok_i,
  input wire logic                 tgt_update_ok_i,
  input wire cfa_pkg::cfa_app_e    app_ind_o,
  input wire logic                 app_ind_stb_o
);
  import cfa_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic taken = cmd_valid_i && cmd_ready_o;

  a_idle_quiet: assert property (cmd_ready_o |-> !rsp_valid_o && !wr_ready_o)
    else $error("data handshake active while idle");
  a_rsp_hold: assert property (rsp_valid_o && !rsp_ready_i |=>
    rsp_valid_o && $stable(rsp_data_o) && $stable(rsp_last_o)) else $error("stalled byte changed");
  a_read_access: assert property (taken && cmd_ins_i == CFA_INS_READ_BIN && !cmd_p1_i[7]
    && tgt_kind_i == CFA_KIND_TRANSPARENT && !tgt_read_ok_i |=> done_o && status_o == CFA_ST_ACCESS)
    else $error("read ran without access");
  a_upd_access: assert property (taken && cmd_ins_i == CFA_INS_UPD_BIN && !cmd_p1_i[7]
    && tgt_kind_i == CFA_KIND_TRANSPARENT && !tgt_update_ok_i |=> done_o && status_o == CFA_ST_ACCESS)
    else $error("update ran without access");
  a_bin_param: assert property (taken && cmd_ins_i != CFA_INS_STATUS && cmd_ins_i != CFA_INS_READ_REC
    && cmd_p1_i[7] && cmd_p1_i[6:5] != 2'b00 |=> done_o && status_o == CFA_ST_BAD_PARAM)
    else $error("reserved offset coding accepted");
  a_sfi_rfu: assert property (taken && cmd_ins_i == CFA_INS_READ_REC && cmd_p2_i[7:3] == 5'h1F
    |=> done_o && status_o == CFA_ST_BAD_PARAM) else $error("reserved file reference accepted");
  a_mode_rfu: assert property (taken && cmd_ins_i == CFA_INS_READ_REC
    && !(cmd_p2_i[2:0] inside {3'h2, 3'h3, 3'h4}) |=> done_o && status_o == CFA_ST_BAD_PARAM)
    else $error("reserved record mode accepted");
  a_stat_rfu: assert property (taken && cmd_ins_i == CFA_INS_STATUS
    && !(cmd_p2_i inside {8'h00, 8'h01, 8'h0C}) |=> done_o && status_o == CFA_ST_BAD_PARAM)
    else $error("reserved status coding accepted");
  a_app_init: assert property (taken && cmd_ins_i == CFA_INS_STATUS && cmd_p1_i == 8'h01
    && cmd_p2_i == 8'h0C |-> ##[1:2] app_ind_stb_o && app_ind_o == CFA_APP_INIT)
    else $error("initialised indication not raised");
  a_upd_no_rsp: assert property (wr_ready_o |-> !rsp_valid_o)
    else $error("update produced response data");
endmodule : cfa_file_cmd_chk

bind cfa_file_cmd cfa_file_cmd_chk #(.SLOT_AW(SLOT_AW)) u_cfa_file_cmd_chk (.clk_i, .rst_i, .cmd_valid_i,
  .cmd_ready_o, .cmd_ins_i, .cmd_p1_i, .cmd_p2_i, .wr_ready_o, .rsp_valid_o, .rsp_data_o, .rsp_last_o,
  .rsp_ready_i, .done_o, .status_o, .tgt_kind_i, .tgt_read_ok_i, .tgt_update_ok_i, .app_ind_o, .app_ind_stb_o);

`default_nettype wire

// [verification/cfa_ftab_model.sv]
/*
  File attribute table answering the interpreter's slot lookup.
  Assumes a same-cycle combinational answer, as the interpreter expects.
*/
`timescale 1ns/1ps
`default_nettype none

module cfa_ftab_model #(
  parameter int SLOT_AW = 8
) (
  // lookup
  input  wire logic [4:0]     file_i,
  input  wire logic           raw_i,
  // attributes
  output cfa_pkg::cfa_kind_e  kind_o,
  output logic [SLOT_AW:0]    size_o,
  output logic [7:0]          rec_len_o,
  output logic [7:0]          rec_cnt_o,
  output logic                read_ok_o,
  output logic                update_ok_o
);
  import cfa_pkg::*;
  // raw_i shows record slots as transparent so the bench can preload them
  always_comb begin
    kind_o      = CFA_KIND_TRANSPARENT;
    size_o      = '0;
    size_o[SLOT_AW] = 1'b1;
    rec_len_o   = 8'h02;
    rec_cnt_o   = 8'h03;
    read_ok_o   = file_i != 5'h04;
    update_ok_o = file_i != 5'h04;
    if (file_i == 5'h02 || file_i == 5'h03) begin
      size_o = (SLOT_AW + 1)'(6);
      if (!raw_i) kind_o = file_i[0] ? CFA_KIND_CYCLIC : CFA_KIND_LINEAR;
    end
  end
endmodule : cfa_ftab_model

`default_nettype wire

// [verification/cfa_file_cmd_test.sv]
/*
  Self-checking bench of the file access interpreter.
  Assumes the attribute table model answers lookups in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module cfa_file_cmd_test;
  import cfa_pkg::*;
  typedef logic [10:0] cfa_note_t;
  localparam logic [3:0] OK = 4'h0, BAD = 4'h1, ACC = 4'h2, ERR = 4'h8;
  logic        clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0, wr_valid_i = 1'b0;
  logic        rsp_ready_i = 1'b1, sel_pulse_i = 1'b0, raw_view = 1'b1;
  logic [7:0]  fcp_len = 8'h03;
  cfa_ins_e    cmd_ins_i = CFA_INS_STATUS;
  logic [7:0]  cmd_p1_i = 8'h00, cmd_p2_i = 8'h00, cmd_len_i = 8'h00, wr_data_i = 8'h00;
  logic [4:0]  sel_file_i = 5'h01, tgt_file_o;
  logic        cmd_ready_o, wr_ready_o, rsp_valid_o, rsp_last_o, done_o, app_ind_stb_o;
  logic        tgt_read_ok_i, tgt_update_ok_i;
  logic [7:0]  rsp_data_o, tgt_rec_len_i, tgt_rec_cnt_i;
  logic [8:0]  tgt_size_i;
  cfa_status_e status_o;
  cfa_kind_e   tgt_kind_i;
  cfa_app_e    app_ind_o;
  logic [7:0]  mir [8192];
  cfa_note_t   exp_q [$];
  int          fails = 0, samples_checked = 0, seed = 72;

  cfa_file_cmd #(.SLOT_AW(8)) u_cfa_file_cmd (.clk_i, .rst_i, .cmd_valid_i, .cmd_ready_o, .cmd_ins_i,
    .cmd_p1_i, .cmd_p2_i, .cmd_len_i, .wr_valid_i, .wr_data_i, .wr_ready_o, .rsp_valid_o, .rsp_data_o,
    .rsp_last_o, .rsp_ready_i, .done_o, .status_o, .sel_file_i, .sel_pulse_i, .tgt_file_o, .tgt_kind_i,
    .tgt_size_i, .tgt_rec_len_i, .tgt_rec_cnt_i, .tgt_read_ok_i, .tgt_update_ok_i, .fcp_len_i(fcp_len),
    .name_len_i(8'h02), .app_ind_o, .app_ind_stb_o);
  cfa_ftab_model #(.SLOT_AW(8)) u_cfa_ftab_model (.file_i(tgt_file_o), .raw_i(raw_view),
    .kind_o(tgt_kind_i), .size_o(tgt_size_i), .rec_len_o(tgt_rec_len_i), .rec_cnt_o(tgt_rec_cnt_i),
    .read_ok_o(tgt_read_ok_i), .update_ok_o(tgt_update_ok_i));

  initial forever #5 clk_i = ~clk_i;
  // random stalls on the response stream
  always @(negedge clk_i) rsp_ready_i = ($random(seed) & 3) != 0;

  task automatic cmp(input cfa_note_t got, input cfa_note_t exp);
    samples_checked++;
    if (exp[8] ? (got[10:3] !== 8'h80 || got[2:0] === 3'h0 || ^got[2:0] === 1'bx) : got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic take_note(input cfa_note_t got);
    if (exp_q.size() == 0) cmp(got, 11'h6FF);
    else cmp(got, exp_q.pop_front());
  endtask : take_note

  task automatic cmp_app(input cfa_app_e got, input cfa_app_e exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_app

  always @(posedge clk_i) if (!rst_i) begin
    if (rsp_valid_o && rsp_ready_i) take_note({1'b0, rsp_last_o, 1'b0, rsp_data_o});
    if (done_o) take_note({3'b100, 5'h00, status_o});
  end

  task automatic issue(input cfa_ins_e ins, input logic [7:0] p1, p2, le);
    cmd_valid_i = 1'b1;
    cmd_ins_i = ins;
    cmd_p1_i = p1;
    cmd_p2_i = p2;
    cmd_len_i = le;
    do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
  endtask : issue

  task automatic finish_cmd;
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (done_o !== 1'b1 && k < 500);
    if (k >= 500) fails++;
    @(negedge clk_i);
  endtask : finish_cmd

  task automatic rd(input cfa_ins_e ins, input logic [7:0] p1, p2, le, input logic [12:0] a,
                    input int n, input logic [3:0] st);
    for (int i = 0; i < n; i++) exp_q.push_back({1'b0, i == n - 1, 1'b0, mir[a + i]});
    exp_q.push_back({1'b1, 1'b0, st[3], 5'h00, st[2:0]});
    issue(ins, p1, p2, le);
    finish_cmd();
  endtask : rd

  task automatic rec(input logic [7:0] p2, p1, input logic [4:0] f, input int r, input logic [3:0] st);
    rd(CFA_INS_READ_REC, p1, p2, 8'h00, {f, 8'(2 * r - 2)}, r ? 2 : 0, st);
  endtask : rec

  task automatic upd(input logic [7:0] p1, p2, input logic [12:0] a, input int n, input logic [3:0] st);
    logic [7:0] d [8];
    for (int i = 0; i < n; i++) begin
      d[i] = 8'($random(seed));
      if (st == OK) mir[a + i] = d[i];
    end
    exp_q.push_back({1'b1, 2'b00, 5'h00, st[2:0]});
    issue(CFA_INS_UPD_BIN, p1, p2, 8'(n));
    // refused updates never raise wr_ready_o, so no bytes are offered
    for (int i = 0; i < n && st == OK; i++) begin
      wr_valid_i = 1'b1;
      wr_data_i = d[i];
      do @(posedge clk_i); while (wr_ready_o !== 1'b1);
      @(negedge clk_i);
    end
    wr_valid_i = 1'b0;
    finish_cmd();
  endtask : upd

  task automatic clear_ptrs;
    sel_pulse_i = 1'b1;
    @(negedge clk_i);
    sel_pulse_i = 1'b0;
  endtask : clear_ptrs

  task automatic close_out;
    if (exp_q.size() != 0) fails++;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  initial begin
    #200000;
    fails++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    upd(8'h81, 8'h10, 13'h0110, 4, OK);
    rd(CFA_INS_READ_BIN, 8'h00, 8'h10, 8'h04, 13'h0110, 4, OK);
    rd(CFA_INS_READ_BIN, 8'h81, 8'h12, 8'h02, 13'h0112, 2, OK);
    upd(8'h00, 8'h11, 13'h0111, 1, OK);
    upd(8'hA0, 8'h10, 13'h0110, 1, BAD);
    rd(CFA_INS_READ_BIN, 8'h01, 8'h00, 8'h01, 13'h0000, 0, ERR);
    rd(CFA_INS_READ_BIN, 8'h00, 8'h10, 8'h04, 13'h0110, 4, OK);
    sel_file_i = 5'h04;
    rd(CFA_INS_READ_BIN, 8'h00, 8'h00, 8'h01, 13'h0400, 0, ACC);
    upd(8'h00, 8'h00, 13'h0400, 1, ACC);
    sel_file_i = 5'h1F;
    upd(8'h00, 8'h00, 13'h1F00, 3, OK);
    sel_file_i = 5'h00;
    upd(8'h00, 8'h00, 13'h0000, 2, OK);
    rd(CFA_INS_STATUS, 8'h00, 8'h01, 8'h00, 13'h0000, 2, OK);
    rd(CFA_INS_STATUS, 8'h00, 8'h01, 8'h01, 13'h0000, 1, OK);
    rd(CFA_INS_STATUS, 8'h00, 8'h00, 8'h00, 13'h1F00, 3, OK);
    fcp_len = 8'h00;
    rd(CFA_INS_STATUS, 8'h00, 8'h00, 8'h00, 13'h0000, 0, OK);
    rd(CFA_INS_STATUS, 8'h01, 8'h0C, 8'h00, 13'h0000, 0, OK);
    cmp_app(app_ind_o, CFA_APP_INIT);
    rd(CFA_INS_STATUS, 8'h02, 8'h0C, 8'h00, 13'h0000, 0, OK);
    cmp_app(app_ind_o, CFA_APP_TERM);
    rd(CFA_INS_STATUS, 8'h00, 8'h05, 8'h00, 13'h0000, 0, BAD);
    upd(8'h82, 8'h00, 13'h0200, 6, OK);
    upd(8'h83, 8'h00, 13'h0300, 6, OK);
    raw_view = 1'b0;
    clear_ptrs();
    rec(8'h14, 8'h00, 5'h02, 0, ERR);
    rec(8'h12, 8'h00, 5'h02, 1, OK);
    rec(8'h12, 8'h00, 5'h02, 2, OK);
    rec(8'h12, 8'h00, 5'h02, 3, OK);
    rec(8'h12, 8'h00, 5'h02, 0, ERR);
    rec(8'h14, 8'h00, 5'h02, 3, OK);
    rec(8'h14, 8'h01, 5'h02, 1, OK);
    rec(8'h14, 8'h05, 5'h02, 0, ERR);
    rec(8'hFA, 8'h00, 5'h02, 0, BAD);
    rec(8'h10, 8'h00, 5'h02, 0, BAD);
    rec(8'h13, 8'h00, 5'h02, 2, OK);
    rec(8'h13, 8'h00, 5'h02, 1, OK);
    rec(8'h13, 8'h00, 5'h02, 0, ERR);
    rec(8'h14, 8'h00, 5'h02, 1, OK);
    sel_file_i = 5'h03;
    clear_ptrs();
    rec(8'h03, 8'h00, 5'h03, 3, OK);
    rec(8'h02, 8'h00, 5'h03, 1, OK);
    rec(8'h03, 8'h00, 5'h03, 3, OK);
    clear_ptrs();
    rec(8'h02, 8'h00, 5'h03, 1, OK);
    close_out();
  end
endmodule : cfa_file_cmd_test

`default_nettype wire
